// ==== hdl/owdiag_pkg.sv ====
// Purpose: shared constants for the open-wire diagnostic and fault masking block
// Assumes: 32-bit AHB-Lite register access, one aligned word per register
// Notes:   offsets, field positions, reset values and codes are named once here
package owdiag_pkg;
	// register byte offsets
	localparam logic [7:0] ctrl_three_off    = 8'h00;
	localparam logic [7:0] mask_off          = 8'h04;
	localparam logic [7:0] uv_off_off        = 8'h08;
	localparam logic [7:0] timer_off         = 8'h0c;
	localparam logic [7:0] status_two_off    = 8'h10;
	localparam logic [7:0] sense_fault_off   = 8'h14;
	localparam logic [7:0] balance_fault_off = 8'h18;
	localparam logic [7:0] fault_clear_off   = 8'h1c;
	localparam logic [7:0] irq_status_off    = 8'h20;
	localparam logic [7:0] irq_mask_off      = 8'h24;
	localparam logic [7:0] protect_en_off    = 8'h28;
	// compare_diag_ctrl_three field positions
	localparam int sink_lsb   = 0;
	localparam int source_lsb = 4;
	localparam int thr_lsb    = 8;
	// compare_source_select code for the open-wire check
	localparam logic [2:0] src_openwire = 3'h3;
	// openwire_sink_select codes
	localparam logic [1:0] sink_off     = 2'h0;
	localparam logic [1:0] sink_balance = 2'h2;
	// reset values
	localparam logic [31:0] ctrl_three_rst = 32'h0000_0000;
	localparam logic [31:0] mask_rst       = 32'h0000_0000;
	// adc_status_two bit positions
	localparam int sense_done_bit   = 0;
	localparam int balance_done_bit = 1;
	// interrupt event bits
	localparam int ev_sense_done   = 0;
	localparam int ev_balance_done = 1;
	localparam int ev_uv           = 2;
	localparam int ev_fault        = 3;
	// comparison sweep step time and derived cycles at 20 MHz
	localparam int clk_hz       = 20_000_000;
	localparam int step_ns      = 200;
	localparam int step_cycles  = (step_ns * (clk_hz / 1_000_000) + 999) / 1000;
	// fixed channel count
	localparam int chan_count   = 6;
endpackage : owdiag_pkg

// ==== hdl/owdiag_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input changes asynchronously to hclk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module owdiag_sync #(
	parameter logic init_val = 1'b0
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// pin and result
	input  wire logic pin_in,
	output var  logic level_out
);
	logic s1_q, s2_q, s3_q; // synchroniser chain
	// chain shifts every cycle; output changes only when stages two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q      <= init_val;
			s2_q      <= init_val;
			s3_q      <= init_val;
			level_out <= init_val;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
		end
	end
endmodule : owdiag_sync
`default_nettype wire

// ==== hdl/owdiag_chan.sv ====
// Purpose: per-channel fault flags for one cell channel
// Assumes: compare strobes are single-cycle pulses from the sweep
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module owdiag_chan (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// evaluation
	input  wire logic sense_hit,
	input  wire logic balance_hit,
	input  wire logic uv_hit,
	input  wire logic clear,
	// flags
	output var  logic sense_flag_q,
	output var  logic balance_flag_q,
	output var  logic uv_flag_q
);
	// sticky flags, set beats clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sense_flag_q   <= 1'b0;
			balance_flag_q <= 1'b0;
			uv_flag_q      <= 1'b0;
		end else begin
			sense_flag_q   <= sense_hit   | (sense_flag_q   & ~clear);
			balance_flag_q <= balance_hit | (balance_flag_q & ~clear);
			uv_flag_q      <= uv_hit      | (uv_flag_q      & ~clear);
		end
	end
endmodule : owdiag_chan
`default_nettype wire

// ==== hdl/owdiag_top.sv ====
// Purpose: open-wire diagnostic, undervoltage and fault output masking
// Assumes: measurements arrive as per-channel codes; single AHB-Lite word transfers
// Notes:   six channels always active; unused channels are hidden by masks, per-channel uv disable and zero balancing timers
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - all six channels always stay active
// - unmasked fault, any channel, pulls fault low
// - enabled protector flags undervoltage unless disabled
// - zero balancing timer skips balancing diagnostic
// - open-wire runs on every channel, unsuppressed
// - source code 011 selects open-wire compare
// - compare measurements against four-bit threshold
// - done flag set; host then disables sinks
module owdiag_top
	import owdiag_pkg::*;
#(
	parameter int chans    = chan_count,
	parameter int meas_w   = 16
) (
	// clock and reset
	input  wire  logic              hclk,
	input  wire  logic              hresetn,
	// ahb-lite slave
	input  wire  logic              hsel,
	input  wire  logic [7:0]        haddr,
	input  wire  logic [1:0]        htrans,
	input  wire  logic              hwrite,
	input  wire  logic [2:0]        hsize,
	input  wire  logic [31:0]       hwdata,
	input  wire  logic              hready,
	output var   logic [31:0]       hrdata,
	output var   logic              hreadyout,
	output var   logic              hresp,
	// measurements, one code per channel
	input  wire  logic [chans*meas_w-1:0] cell_voltage_result,
	input  wire  logic [chans*meas_w-1:0] aux_cell_result,
	input  wire  logic [meas_w-1:0] uv_threshold,
	// measurement-valid pin from the converter side, asynchronous
	input  wire  logic              meas_valid_pin,
	// balancing diagnostic miscompare per channel
	input  wire  logic [chans-1:0]  balance_diag_hit,
	// outputs
	output var   logic              fault_out_n,
	output var   logic [1:0]        sink_drive,
	output var   logic              irq
);
	// six channels are fixed; the threshold needs room below its four bits
	// all active
	if (chans != 6 || meas_w <= 4) begin : g_chk
		$error("channel count must stay six");
	end

	// registers
	logic [31:0] compare_diag_ctrl_three_q; // sink, source select, threshold
	logic [31:0] compare_fault_mask_q;      // [0]=sense ow,[1]=balance ow,[2]=uv,[3]=cb diag
	logic [chans-1:0] undervolt_chan_off_q; // per-channel undervolt_chan_off
	logic [chans-1:0] balance_timer_nz_q;   // nonzero timer per channel
	logic              cell_voltage_protector_q;
	logic [1:0]  adc_status_two_q;          // done flags
	logic [3:0]  irq_stat_q;
	logic [3:0]  irq_mask_q;
	logic        ph_valid_q;  // data phase pending
	logic        ph_write_q;
	logic [7:0]  ph_addr_q;

	// decoded fields
	wire [1:0] openwire_sink_select  = compare_diag_ctrl_three_q[sink_lsb +: 2];
	wire [2:0] compare_source_select = compare_diag_ctrl_three_q[source_lsb +: 3];
	wire [3:0] openwire_threshold    = compare_diag_ctrl_three_q[thr_lsb +: 4];
	// threshold scaled to measurement width, top bits
	wire [meas_w-1:0] ow_thr_full = {openwire_threshold, {(meas_w-4){1'b0}}};

	// bus decode
	wire addr_take  = hsel & hready & htrans[1];
	wire wr_now     = ph_valid_q & ph_write_q;
	wire rd_now     = ph_valid_q & ~ph_write_q;
	wire wr_ctrl    = wr_now & (ph_addr_q == ctrl_three_off);
	wire wr_mask    = wr_now & (ph_addr_q == mask_off);
	wire wr_uvoff   = wr_now & (ph_addr_q == uv_off_off);
	wire wr_timer   = wr_now & (ph_addr_q == timer_off);
	wire wr_clear   = wr_now & (ph_addr_q == fault_clear_off);
	wire wr_imask   = wr_now & (ph_addr_q == irq_mask_off);
	wire wr_prot    = wr_now & (ph_addr_q == protect_en_off);
	wire rd_irqstat = rd_now & (ph_addr_q == irq_status_off);
	wire clr_status = wr_clear & hwdata[8];

	// measurement valid synchronised, rising edge starts a sweep
	logic meas_valid_s;
	logic meas_valid_d1_q;
	owdiag_sync #(.init_val(1'b0)) u_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_in    (meas_valid_pin),
		.level_out (meas_valid_s)
	);
	wire meas_rise = meas_valid_s & ~meas_valid_d1_q;

	// comparison sequencer
	typedef enum logic [1:0] {st_idle = 2'b00, st_wait = 2'b01, st_cmp = 2'b11} seq_t;
	seq_t        seq_q;
	logic [7:0]  step_cnt_q;
	logic [2:0]  ch_q;
	logic        ow_balance_q; // balance-pin check when set
	wire ow_start = (seq_q == st_idle) & meas_rise & (compare_source_select == src_openwire);
	wire last_ch  = (ch_q == 3'(chans-1));
	wire cmp_fire = (seq_q == st_cmp);
	wire sweep_end = cmp_fire & last_ch;

	// measurement of current channel
	wire [meas_w-1:0] vc_m = cell_voltage_result[ch_q*meas_w +: meas_w];
	wire [meas_w-1:0] cb_m = aux_cell_result[ch_q*meas_w +: meas_w];

	wire [chans-1:0] sense_hit;
	wire [chans-1:0] balance_hit;
	wire [chans-1:0] uv_hit;
	wire [chans-1:0] sense_fl, balance_fl, uv_fl;
	wire [chans-1:0] cb_fl;
	logic [chans-1:0] cb_flag_q;

	genvar gi;
	for (gi = 0; gi < chans; gi++) begin : g_ch
		assign sense_hit[gi]   = cmp_fire & ~ow_balance_q & (ch_q == 3'(gi)) & (vc_m < ow_thr_full);
		assign balance_hit[gi] = cmp_fire &  ow_balance_q & (ch_q == 3'(gi)) & (cb_m < ow_thr_full);
		assign uv_hit[gi] = cell_voltage_protector_q & ~undervolt_chan_off_q[gi]
			& (cell_voltage_result[gi*meas_w +: meas_w] < uv_threshold);
		owdiag_chan u_chan (
			.hclk           (hclk),
			.hresetn        (hresetn),
			.sense_hit      (sense_hit[gi]),
			.balance_hit    (balance_hit[gi]),
			.uv_hit         (uv_hit[gi]),
			.clear          (clr_status),
			.sense_flag_q   (sense_fl[gi]),
			.balance_flag_q (balance_fl[gi]),
			.uv_flag_q      (uv_fl[gi])
		);
		assign cb_fl[gi] = balance_diag_hit[gi] & balance_timer_nz_q[gi];
	end

	// sequencer: wait step_cycles, then walk channels one per cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_q        <= st_idle;
			step_cnt_q   <= 8'h00;
			ch_q         <= 3'h0;
			ow_balance_q <= 1'b0;
		end else begin
			unique case (seq_q)
				st_idle: if (ow_start) begin
					seq_q        <= st_wait;
					step_cnt_q   <= 8'(step_cycles);
					ow_balance_q <= (openwire_sink_select == sink_balance);
					ch_q         <= 3'h0;
				end
				st_wait: begin
					step_cnt_q <= step_cnt_q - 8'h01;
					if (step_cnt_q == 8'h01) seq_q <= st_cmp;
				end
				st_cmp: begin
					ch_q <= ch_q + 3'h1;
					if (last_ch) seq_q <= st_idle;
				end
				// code 10 is never used; fall back to idle
				default: seq_q <= st_idle;
			endcase
		end
	end

	// done flags; set wins, cleared by status clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_status_two_q <= 2'b00;
			meas_valid_d1_q  <= 1'b0;
		end else begin
			meas_valid_d1_q <= meas_valid_s;
			adc_status_two_q[sense_done_bit] <= (sweep_end & ~ow_balance_q)
				| (adc_status_two_q[sense_done_bit] & ~clr_status);
			adc_status_two_q[balance_done_bit] <= (sweep_end & ow_balance_q)
				| (adc_status_two_q[balance_done_bit] & ~clr_status);
		end
	end

	// balancing diagnostic sticky flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cb_flag_q <= '0;
		else          cb_flag_q <= cb_fl | (cb_flag_q & ~{chans{clr_status}});
	end

	// software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_diag_ctrl_three_q <= ctrl_three_rst;
			compare_fault_mask_q      <= mask_rst;
			undervolt_chan_off_q      <= '0;
			balance_timer_nz_q        <= '0;
			cell_voltage_protector_q  <= 1'b0;
			irq_mask_q                <= 4'h0;
		end else begin
			if (wr_ctrl)  compare_diag_ctrl_three_q <= hwdata;
			if (wr_mask)  compare_fault_mask_q      <= hwdata;
			if (wr_uvoff) undervolt_chan_off_q      <= hwdata[chans-1:0];
			if (wr_timer) balance_timer_nz_q        <= hwdata[chans-1:0];
			if (wr_prot)  cell_voltage_protector_q  <= hwdata[0];
			if (wr_imask) irq_mask_q                <= hwdata[3:0];
		end
	end

	// fault aggregation behind the masks
	wire any_sense   = |sense_fl   & ~compare_fault_mask_q[0];
	wire any_balance = |balance_fl & ~compare_fault_mask_q[1];
	wire any_uv      = |uv_fl      & ~compare_fault_mask_q[2];
	wire any_cb      = |cb_flag_q  & ~compare_fault_mask_q[3];
	wire fault_any   = any_sense | any_balance | any_uv | any_cb;
	wire [3:0] ev    = {fault_any, |uv_hit,
		sweep_end & ow_balance_q, sweep_end & ~ow_balance_q};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) fault_out_n <= 1'b1;
		else          fault_out_n <= ~fault_any;
	end

	// interrupt status: set wins over read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= 4'h0;
			irq        <= 1'b0;
		end else begin
			irq_stat_q <= ev | (irq_stat_q & ~{4{rd_irqstat}});
			// a set mask bit hides its event, as in the compare fault mask
			irq        <= |(irq_stat_q & ~irq_mask_q);
		end
	end

	// sink drive follows the host's field
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) sink_drive <= sink_off;
		else          sink_drive <= openwire_sink_select;
	end

	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr)
			ctrl_three_off:    rd_mux = compare_diag_ctrl_three_q;
			mask_off:          rd_mux = compare_fault_mask_q;
			uv_off_off:        rd_mux[chans-1:0] = undervolt_chan_off_q;
			timer_off:         rd_mux[chans-1:0] = balance_timer_nz_q;
			status_two_off:    rd_mux[1:0] = adc_status_two_q;
			sense_fault_off:   rd_mux[chans-1:0] = sense_fl;
			balance_fault_off: rd_mux[chans-1:0] = balance_fl;
			fault_clear_off:   rd_mux[chans-1:0] = uv_fl;
			irq_status_off:    rd_mux[3:0] = irq_stat_q;
			irq_mask_off:      rd_mux[3:0] = irq_mask_q;
			protect_en_off:    rd_mux[0] = cell_voltage_protector_q;
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// bus phases: zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q  <= 8'h00;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			ph_valid_q <= addr_take;
			ph_write_q <= hwrite;
			ph_addr_q  <= {haddr[7:2], 2'b00};
			if (addr_take & ~hwrite) hrdata <= rd_mux;
		end
	end

	// assertions
	fault_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fault_any |=> !fault_out_n) else $error("fault pin not asserted");
	fault_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!fault_any |=> fault_out_n) else $error("fault pin stuck low");
	done_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(sweep_end && !ow_balance_q) |=> adc_status_two_q[sense_done_bit])
		else $error("sense done not set");
	start_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(seq_q == st_idle && $past(seq_q) == st_idle) ##1 seq_q == st_wait
		|-> $past(compare_source_select, 1) == src_openwire)
		else $error("sweep without open-wire code");
	sweep_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(seq_q == st_cmp) |-> (seq_q == st_cmp)[*6] ##1 seq_q == st_idle)
		else $error("sweep not six channels");
	// newly set uv flags only on enabled channels with the protector on
	uv_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((uv_fl & ~$past(uv_fl)
		& $past(undervolt_chan_off_q | {chans{~cell_voltage_protector_q}})) == '0))
		else $error("uv on disabled channel");
	// newly set balancing flags never on a zero-timer channel
	cb_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((cb_flag_q & ~$past(cb_flag_q) & ~$past(balance_timer_nz_q)) == '0))
		else $error("cb fault on zero timer");
	thr_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(cmp_fire && !ow_balance_q && vc_m < ow_thr_full) |=> sense_fl[$past(ch_q)])
		else $error("open-wire hit lost");
	active_six_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(seq_q == st_cmp) |-> ch_q == 3'h0) else $error("channel skipped");
endmodule : owdiag_top
`default_nettype wire

// ==== sim/owdiag_host.sv ====
// Purpose: host model that owns the register bus and runs the open-wire steps
// Assumes: one slave whose hreadyout comes back as hready
// Notes:   every wait is bounded; a wait that runs out sets hang
`timescale 1ns/1ps
`default_nettype none
module owdiag_host
	import owdiag_pkg::*;
#(
	parameter int         settle_cycles = 8,       // capacitor discharge wait, shortened
	parameter logic [5:0] used_chans    = 6'h0f    // channels wired to cells
) (
	// clock
	input  wire logic        hclk,
	// bus master side
	output var  logic        hsel,
	output var  logic [7:0]  haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	bit         hang;        // a bounded wait ran out
	logic [5:0] act_faults;  // faults the host acts on
	logic [31:0] scratch;    // discarded read data

	// idle bus from time zero
	// quiet idle line
	initial begin
		hang = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// wait for hready high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1) begin
			hang = 1'b1;
		end
	endtask : wait_ready

	// one single word transfer; data phase without a next address phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? wd : ~hwdata;
		wait_ready();
		rd = hrdata;
		// released write data never keeps its value
		hwdata <= ~wd;
	endtask : xfer

	// arm an open-wire check up to the source select
	task automatic ow_arm(input logic [1:0] sink, input logic [3:0] thr, input logic [31:0] msk);
		xfer(1'b1, mask_off, msk, scratch);
		xfer(1'b1, ctrl_three_off, {20'h0, thr, 1'b0, 3'h0, 2'h0, sink}, scratch);
		repeat (settle_cycles) @(posedge hclk);
		xfer(1'b1, ctrl_three_off, {20'h0, thr, 1'b0, src_openwire, 2'h0, sink}, scratch);
	endtask : ow_arm

	// finish the check: results read by hand, then clear before unmask
	task automatic ow_close(input logic bal, output logic [31:0] st, output logic [31:0] f);
		xfer(1'b0, status_two_off, 32'h0, st);
		xfer(1'b1, ctrl_three_off, {30'h0, sink_off}, scratch);
		xfer(1'b0, bal ? balance_fault_off : sense_fault_off, 32'h0, f);
		act_faults = f[5:0] & used_chans;
		xfer(1'b1, fault_clear_off, 32'h100, scratch);
		xfer(1'b1, mask_off, 32'h0, scratch);
	endtask : ow_close
endmodule : owdiag_host
`default_nettype wire

// ==== sim/open_wire_diag_fault_masking_tb_top.sv ====
// Purpose: self-checking bench for open-wire checks and fault masking
// Assumes: host model owns the bus; bench drives the converter side
// Notes:   random cell codes from a fixed seed, with corner codes mixed in
`timescale 1ns/1ps
`default_nettype none
module open_wire_diag_fault_masking_tb_top
	import owdiag_pkg::*;
;
	logic        hclk;         // 20 MHz bus clock
	logic        hresetn;      // async reset, active low
	logic        hsel;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;    // fed back as hready
	logic        hresp;
	logic [95:0] cells;        // cell codes, ch0 low
	logic [95:0] aux;          // balance pin codes
	logic [95:0] cv;           // code staging
	logic [15:0] uv_thr;
	logic        meas_valid;
	logic [5:0]  cb_hit;       // balancing diag miscompare
	logic        fault_out_n;
	logic [1:0]  sink_drive;
	logic        irq;
	logic [31:0] rv;           // last read data
	logic [31:0] st;           // last status two
	logic [3:0]  thr;
	logic [1:0]  sink;
	int          error_cnt;
	int          comparisons;

	// free running clock
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	owdiag_top i_owdiag_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cell_voltage_result(cells), .aux_cell_result(aux), .uv_threshold(uv_thr),
		.meas_valid_pin(meas_valid), .balance_diag_hit(cb_hit),
		.fault_out_n(fault_out_n), .sink_drive(sink_drive), .irq(irq)
	);

	owdiag_host u_host (
		.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
	);

	// verdict and end of run
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	// register value compare
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_reg

	// pin level compare
	task automatic chk_pin(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk_pin

	// a hung bus ends the run
	task automatic guard;
		if (u_host.hang) begin
			error_cnt++;
			$display("mismatch at %0t: bus wait ran out", $time);
			test_done();
		end
	endtask : guard

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(w, a, d, rv);
		guard();
	endtask : bus

	// measurement-valid pulse, then long enough for sync, wait and a full sweep
	task automatic pulse_meas;
		@(posedge hclk);
		meas_valid <= 1'b1;
		repeat (3) @(posedge hclk);
		meas_valid <= 1'b0;
		repeat (30) @(posedge hclk);
	endtask : pulse_meas

	// channels whose code lies under the threshold
	function automatic logic [5:0] ow_exp(input logic [95:0] m, input logic [3:0] t);
		for (int c = 0; c < 6; c++) begin
			ow_exp[c] = m[c*16 +: 16] < {t, 12'h000};
		end
	endfunction : ow_exp

	function automatic logic [95:0] rand_cells;
		for (int c = 0; c < 6; c++) begin
			rand_cells[c*16 +: 16] = 16'($urandom());
		end
	endfunction : rand_cells

	// main sequence
	initial begin
		hresetn = 1'b0;
		cells = 96'h0;
		aux = 96'h0;
		uv_thr = 16'h0;
		meas_valid = 1'b0;
		cb_hit = 6'h0;
		error_cnt = 0;
		comparisons = 0;
		void'($urandom(32'hcc04));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values, unmapped place
		bus(1'b0, ctrl_three_off, 32'h0);
		chk_reg(rv, ctrl_three_rst, "ctrl reset");
		bus(1'b0, mask_off, 32'h0);
		chk_reg(rv, mask_rst, "mask reset");
		bus(1'b1, 8'h3c, 32'hffff_ffff);
		bus(1'b0, 8'h3c, 32'h0);
		chk_reg(rv, 32'h0, "unmapped read");
		chk_pin(fault_out_n, 1'b1, "fault idle");
		chk_pin(hresp, 1'b0, "okay response");
		bus(1'b1, irq_mask_off, 32'hf);
		$display("test reset done");
		// masked sweeps, sense and balance pins, corner codes first
		for (int i = 0; i < 6; i++) begin
			thr = 4'($urandom_range(15, 1));
			sink = (i % 2) ? sink_balance : 2'h1;
			cv = rand_cells();
			if (i < 2) begin
				cv[32 +: 16] = {thr, 12'h000};
				cv[80 +: 16] = 16'h0;
			end
			cells <= cv;
			aux <= {cv[15:0], cv[95:16]};
			u_host.ow_arm(sink, thr, 32'hf);
			guard();
			chk_reg({30'h0, sink_drive}, {30'h0, sink}, "sink drive");
			pulse_meas();
			chk_pin(fault_out_n, 1'b1, "masked sweep");
			u_host.ow_close(i % 2, st, rv);
			guard();
			chk_pin(st[(i % 2) ? balance_done_bit : sense_done_bit], 1'b1, "done flag");
			chk_reg(rv, {26'h0, ow_exp((i % 2) ? {cv[15:0], cv[95:16]} : cv, thr)}, "ow");
			chk_pin(fault_out_n, 1'b1, "after clear");
		end
		$display("test masked sweeps done");
		// unmasked sweep, only the unused top channel open
		cells <= {16'h0, {5{16'hffff}}};
		u_host.ow_arm(2'h1, 4'h8, 32'h0);
		pulse_meas();
		chk_pin(fault_out_n, 1'b0, "unused channel fault");
		u_host.ow_close(1'b0, st, rv);
		guard();
		chk_reg(rv, 32'h20, "unused channel flag");
		chk_reg({26'h0, u_host.act_faults}, 32'h0, "unused ignored");
		chk_pin(fault_out_n, 1'b1, "fault released");
		bus(1'b1, irq_mask_off, 32'h0);
		repeat (2) @(posedge hclk);
		chk_pin(irq, 1'b1, "irq raised");
		bus(1'b0, irq_status_off, 32'h0);
		chk_reg(rv & 32'h9, 32'h9, "irq events");
		repeat (2) @(posedge hclk);
		chk_pin(irq, 1'b0, "irq cleared");
		bus(1'b1, irq_mask_off, 32'hf);
		$display("test unmasked sweep done");
		// every source code; only the open-wire code sweeps all six
		cells <= 96'h0;
		bus(1'b1, mask_off, 32'hf);
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, fault_clear_off, 32'h100);
			bus(1'b1, ctrl_three_off, 32'hf01 | (32'(s) << source_lsb));
			pulse_meas();
			bus(1'b0, sense_fault_off, 32'h0);
			chk_reg(rv, (s == 3) ? 32'h3f : 32'h0, "source code");
		end
		bus(1'b1, fault_clear_off, 32'h100);
		bus(1'b1, mask_off, 32'h0);
		$display("test source codes done");
		// undervoltage on unused channels, then disabled per channel
		cells <= {{2{16'h0000}}, {4{16'h9000}}};
		uv_thr <= 16'h8000;
		pulse_meas();
		bus(1'b0, fault_clear_off, 32'h0);
		chk_reg(rv, 32'h0, "protector off");
		bus(1'b1, protect_en_off, 32'h1);
		pulse_meas();
		bus(1'b0, fault_clear_off, 32'h0);
		chk_reg(rv, 32'h30, "uv unused");
		chk_pin(fault_out_n, 1'b0, "uv fault");
		bus(1'b1, uv_off_off, 32'h30);
		bus(1'b1, fault_clear_off, 32'h100);
		pulse_meas();
		bus(1'b0, fault_clear_off, 32'h0);
		chk_reg(rv, 32'h0, "uv disabled");
		chk_pin(fault_out_n, 1'b1, "uv released");
		bus(1'b1, protect_en_off, 32'h0);
		$display("test undervoltage done");
		// balancing diag skipped where the timer is zero
		bus(1'b1, timer_off, 32'h0f);
		cb_hit <= 6'h30;
		pulse_meas();
		chk_pin(fault_out_n, 1'b1, "timer zero");
		cb_hit <= 6'h01;
		pulse_meas();
		chk_pin(fault_out_n, 1'b0, "timer set");
		cb_hit <= 6'h00;
		bus(1'b1, fault_clear_off, 32'h100);
		repeat (2) @(posedge hclk);
		chk_pin(fault_out_n, 1'b1, "diag cleared");
		$display("test balancing diag done");
		test_done();
	end
endmodule : open_wire_diag_fault_masking_tb_top
`default_nettype wire
